// ---- rtl/mailbox_pkg.sv ----
// Package for the parallel mailbox port control and flag logic.
// Assumes one system clock; used by the port control module, the host model and the bench.
package mailbox_pkg;
  // Register addresses on the processor bus
  localparam logic [15:0] FLAG_ADDR = 16'hDF78;
  localparam logic [15:0] ENABLE_ADDR = 16'hDF79;
  localparam logic [15:0] CMD_SLOT_ADDR = 16'hDF7B;
  localparam logic [15:0] DATA_SLOT_ADDR = 16'hDF7F;
  // Slot select codes on the host side
  localparam logic [2:0] SEL_FLAG = 3'h0;
  localparam logic [2:0] SEL_ENABLE = 3'h1;
  localparam logic [2:0] SEL_CMD = 3'h3;
  localparam logic [2:0] SEL_DATA = 3'h7;
  // Reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // Enable bit positions
  localparam int EN_PORT = 0;
  localparam int EN_STROBE = 1;
  localparam int EN_CMD_OUT = 2;
  localparam int EN_CMD_IN = 3;
  localparam int EN_PROC_HS = 4;
  localparam int EN_HOST_HS = 5;
  localparam int EN_DATA_OUT = 6;
  localparam int EN_DATA_IN = 7;
  // Flag bit positions
  localparam int FL_CMD_OUT = 2;
  localparam int FL_CMD_IN = 3;
  localparam int FL_PROC_HS = 4;
  localparam int FL_HOST_HS = 5;
  localparam int FL_DATA_OUT = 6;
  localparam int FL_DATA_IN = 7;
  // Write masks per side
  localparam logic [7:0] HOST_EN_MASK = 8'h54;
  localparam logic [7:0] PROC_EN_MASK = 8'hAB;
  // Host-side access strobes after synchronising
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
  } host_acc_t;
  // Whole module state
  typedef struct packed {
    logic [7:0] enable_q;
    logic [7:0] flag_q;
    logic [7:0] cmd_slot_q;
    logic [7:0] data_slot_q;
    logic [7:0] proc_rdata_q;
    logic [7:0] host_rdata_q;
    logic host_oe_n_q;
    logic proc_irq_q;
    logic host_irq_q;
    logic [2:0] rd_sync_q;
    logic [2:0] wr_sync_q;
    logic rd_level_q; // Last agreed level of the host read strobe
    logic wr_level_q; // Last agreed level of the host write strobe
    logic [7:0] hdata_q;
    logic [2:0] hsel_q;
  } state_t;
endpackage : mailbox_pkg

// ---- rtl/parallel_mailbox_port.sv ----
// Control, flag and auto-handshake slot logic of the parallel mailbox port.
// Assumes the host strobes arrive asynchronously and data/select are stable
// for the width of a strobe; processor accesses are one-cycle pulses.
// How it works
// - Enable bits switch port and strobes
// - Bits 3,7 enable inbound slot interrupts
// - Enable bits 2,4,6 written only by host
// - Bits 0,1,3,5,7 and flag4 processor-only
// - Bits 4,5 enable handshake interrupts
// - Host command write sets flag 3
// - Processor command read clears flag 3
// - Slot flags change only on slot events
// - Host writes flag 5, processor reads
// - Processor writes flag 4, host reads
// - Flag bits 1,0 read zero
// - Command slot carries opcodes
// - Data slot carries data or addresses
// - Both sides read and write slots
`timescale 1ns/1ps
module parallel_mailbox_port
  import mailbox_pkg::*;
(
  input wire logic clk_sys,            // System clock
  input wire logic sys_rst,            // Synchronous reset, high
  input wire logic [15:0] proc_addr,   // Processor address
  input wire logic proc_wr,            // Processor write pulse
  input wire logic proc_rd,            // Processor read pulse
  input wire logic [7:0] proc_wdata,   // Processor write data
  output logic [7:0] proc_rdata,       // Processor read data, registered
  input wire logic read_strobe_n,      // Host read strobe, low
  input wire logic write_strobe_n,     // Host write strobe, low
  input wire logic [2:0] slot_select,  // Host register select
  input wire logic [7:0] host_data_i,  // Host data bus in
  output logic [7:0] host_data_o,      // Host data bus out
  output logic host_data_oe_n,         // Host bus drive enable, low
  output logic proc_irq,               // Interrupt to processor
  output logic host_irq                // Interrupt to host
);

  state_t s_q; // Registered state
  state_t s_d; // Next state
  host_acc_t ha; // Host access events this cycle
  logic port_on; // Port and strobes enabled
  logic p_wr_flag; // Processor writes flag register
  logic p_wr_en; // Processor writes enable register
  logic p_wr_cmd; // Processor writes command slot
  logic p_wr_data; // Processor writes data slot
  logic p_rd_cmd; // Processor reads command slot
  logic p_rd_data; // Processor reads data slot
  logic h_wr_flag; // Host writes flag register
  logic h_wr_en; // Host writes enable register
  logic h_wr_cmd; // Host writes command slot
  logic h_wr_data; // Host writes data slot
  logic h_rd_cmd; // Host reads command slot
  logic h_rd_data; // Host reads data slot
  logic [7:0] fl; // Working flag value

  // Host strobe edges: a fall counts once stages 2 and 3 agree on low
  always_comb begin
    port_on = s_q.enable_q[EN_PORT] && s_q.enable_q[EN_STROBE];
    ha.sel = s_q.hsel_q;
    // Both stages low while the last agreed level was still high
    ha.wr = port_on && !s_q.wr_sync_q[1] && !s_q.wr_sync_q[2] && s_q.wr_level_q;
    ha.rd = port_on && !s_q.rd_sync_q[1] && !s_q.rd_sync_q[2] && s_q.rd_level_q;
  end

  // Decode of accesses from both sides
  always_comb begin
    p_wr_flag = proc_wr && (proc_addr == FLAG_ADDR);
    p_wr_en = proc_wr && (proc_addr == ENABLE_ADDR);
    p_wr_cmd = proc_wr && (proc_addr == CMD_SLOT_ADDR);
    p_wr_data = proc_wr && (proc_addr == DATA_SLOT_ADDR);
    p_rd_cmd = proc_rd && (proc_addr == CMD_SLOT_ADDR);
    p_rd_data = proc_rd && (proc_addr == DATA_SLOT_ADDR);
    h_wr_flag = ha.wr && (ha.sel == SEL_FLAG);
    h_wr_en = ha.wr && (ha.sel == SEL_ENABLE);
    h_wr_cmd = ha.wr && (ha.sel == SEL_CMD);
    h_wr_data = ha.wr && (ha.sel == SEL_DATA);
    h_rd_cmd = ha.rd && (ha.sel == SEL_CMD);
    h_rd_data = ha.rd && (ha.sel == SEL_DATA);
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    fl = s_q.flag_q;
    // Three-stage synchronisers; stage 1 feeds only stage 2
    s_d.rd_sync_q = {s_q.rd_sync_q[1:0], read_strobe_n};
    s_d.wr_sync_q = {s_q.wr_sync_q[1:0], write_strobe_n};
    // Agreed level moves only once stages 2 and 3 show the same value
    if (s_q.rd_sync_q[1] == s_q.rd_sync_q[2]) s_d.rd_level_q = s_q.rd_sync_q[2];
    if (s_q.wr_sync_q[1] == s_q.wr_sync_q[2]) s_d.wr_level_q = s_q.wr_sync_q[2];
    // Capture host data and select every cycle; a strobe event uses the copy
    // taken just before it, while the host still holds them steady
    s_d.hdata_q = host_data_i;
    s_d.hsel_q = slot_select;
    // Enable register: each side writes only its own bits
    if (p_wr_en) begin
      s_d.enable_q = (s_d.enable_q & ~PROC_EN_MASK) | (proc_wdata & PROC_EN_MASK);
    end
    if (h_wr_en) begin
      s_d.enable_q = (s_d.enable_q & ~HOST_EN_MASK) | (s_q.hdata_q & HOST_EN_MASK);
    end
    // Manual handshake bits, each written by one side only
    if (p_wr_flag) begin
      fl[FL_PROC_HS] = proc_wdata[FL_PROC_HS];
    end
    if (h_wr_flag) begin
      fl[FL_HOST_HS] = s_q.hdata_q[FL_HOST_HS];
    end
    // Slot clears first, sets after so a set wins
    if (p_rd_cmd) fl[FL_CMD_IN] = 1'b0;
    if (p_rd_data) fl[FL_DATA_IN] = 1'b0;
    if (h_rd_cmd) fl[FL_CMD_OUT] = 1'b0;
    if (h_rd_data) fl[FL_DATA_OUT] = 1'b0;
    // Writes into a slot raise the flag toward the reading side
    if (h_wr_cmd) fl[FL_CMD_IN] = 1'b1;
    if (h_wr_data) fl[FL_DATA_IN] = 1'b1;
    if (p_wr_cmd) fl[FL_CMD_OUT] = 1'b1;
    if (p_wr_data) fl[FL_DATA_OUT] = 1'b1;
    // Low bits are reserved and always read as zero
    fl[1:0] = 2'h0;
    s_d.flag_q = fl;
    // Slots: both sides write, processor wins on a tie
    if (h_wr_cmd) s_d.cmd_slot_q = s_q.hdata_q;
    if (h_wr_data) s_d.data_slot_q = s_q.hdata_q;
    if (p_wr_cmd) s_d.cmd_slot_q = proc_wdata;
    if (p_wr_data) s_d.data_slot_q = proc_wdata;
    // Processor read data
    case (proc_addr)
      FLAG_ADDR: s_d.proc_rdata_q = s_q.flag_q;
      ENABLE_ADDR: s_d.proc_rdata_q = s_q.enable_q;
      CMD_SLOT_ADDR: s_d.proc_rdata_q = s_q.cmd_slot_q;
      DATA_SLOT_ADDR: s_d.proc_rdata_q = s_q.data_slot_q;
      default: s_d.proc_rdata_q = 8'h00;
    endcase
    // Host read data, driven while read strobe held low
    case (s_q.hsel_q)
      SEL_FLAG: s_d.host_rdata_q = s_q.flag_q;
      SEL_ENABLE: s_d.host_rdata_q = s_q.enable_q;
      SEL_CMD: s_d.host_rdata_q = s_q.cmd_slot_q;
      SEL_DATA: s_d.host_rdata_q = s_q.data_slot_q;
      default: s_d.host_rdata_q = 8'h00;
    endcase
    // Host bus driven only during an agreed read strobe with the port on
    s_d.host_oe_n_q = !(port_on && !s_q.rd_sync_q[1] && !s_q.rd_sync_q[2]);
    // Interrupts: flag and enable both set, port on
    s_d.proc_irq_q = s_q.enable_q[EN_PORT] && (
      (s_q.flag_q[FL_CMD_IN] && s_q.enable_q[EN_CMD_IN]) ||
      (s_q.flag_q[FL_DATA_IN] && s_q.enable_q[EN_DATA_IN]) ||
      (s_q.flag_q[FL_HOST_HS] && s_q.enable_q[EN_HOST_HS]));
    s_d.host_irq_q = s_q.enable_q[EN_PORT] && (
      (s_q.flag_q[FL_CMD_OUT] && s_q.enable_q[EN_CMD_OUT]) ||
      (s_q.flag_q[FL_DATA_OUT] && s_q.enable_q[EN_DATA_OUT]) ||
      (s_q.flag_q[FL_PROC_HS] && s_q.enable_q[EN_PROC_HS]));
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.enable_q <= ENABLE_RESET;
      s_q.flag_q <= FLAG_RESET;
      s_q.host_oe_n_q <= 1'b1;
      s_q.rd_sync_q <= 3'h7;
      s_q.wr_sync_q <= 3'h7;
      s_q.rd_level_q <= 1'b1;
      s_q.wr_level_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign proc_rdata = s_q.proc_rdata_q;
  assign host_data_o = s_q.host_rdata_q;
  assign host_data_oe_n = s_q.host_oe_n_q;
  assign proc_irq = s_q.proc_irq_q;
  assign host_irq = s_q.host_irq_q;

  // Checks
  // Reset leaves both registers cleared
  a_reset_clears: assert property (@(posedge clk_sys)
    sys_rst |=> (s_q.enable_q == 8'h00 && s_q.flag_q == 8'h00))
    else $error("reset did not clear registers");
  // Host enable writes leave processor bits alone
  a_host_en_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_en && !p_wr_en |=> (s_q.enable_q & PROC_EN_MASK) == ($past(s_q.enable_q) & PROC_EN_MASK))
    else $error("host changed processor enable bits");
  // Processor enable writes leave host bits alone
  a_proc_en_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_en && !h_wr_en |=> (s_q.enable_q & HOST_EN_MASK) == ($past(s_q.enable_q) & HOST_EN_MASK))
    else $error("processor changed host enable bits");
  // Host command write raises flag 3
  a_cmd_in_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_cmd |=> s_q.flag_q[FL_CMD_IN])
    else $error("host command write did not set flag");
  // Processor command read drops flag 3
  a_cmd_in_clr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_rd_cmd && !h_wr_cmd |=> !s_q.flag_q[FL_CMD_IN])
    else $error("processor command read did not clear flag");
  // Reserved flag bits stay zero
  a_low_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.flag_q[1:0] == 2'h0)
    else $error("flag low bits not zero");
  // Flag 3 moves only on command slot events
  a_slot_flag_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(p_rd_cmd || h_wr_cmd) |=> s_q.flag_q[FL_CMD_IN] == $past(s_q.flag_q[FL_CMD_IN]))
    else $error("command flag changed without slot event");
  // Processor handshake bit takes the written value
  a_proc_hs: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_flag |=> s_q.flag_q[FL_PROC_HS] == $past(proc_wdata[FL_PROC_HS]))
    else $error("processor handshake bit not written");
  // Processor interrupt needs a flag and its enable
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    proc_irq |-> $past(s_q.enable_q[EN_PORT]) && $past(s_q.flag_q & s_q.enable_q & 8'hA8) != 8'h00)
    else $error("processor interrupt without flag and enable");
  // Processor data write raises flag 6, then the host interrupt when enabled
  a_data_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_data |=> s_q.flag_q[FL_DATA_OUT] ##1
      (!($past(s_q.enable_q[EN_PORT]) && $past(s_q.enable_q[EN_DATA_OUT])) || host_irq))
    else $error("processor data write did not raise host flag");
  // No host bus drive while port or strobes are off
  a_oe_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(s_q.enable_q[EN_PORT] && s_q.enable_q[EN_STROBE]) |=> host_data_oe_n)
    else $error("host bus driven while port disabled");
  // One host write event per strobe fall
  a_strobe_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ha.wr |=> !ha.wr)
    else $error("host write event repeated");
  // Host handshake bit takes the host's value
  a_host_hs_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_flag |=> s_q.flag_q[FL_HOST_HS] == $past(s_q.hdata_q[FL_HOST_HS]))
    else $error("host handshake bit not written");
  // Processor flag writes leave the host handshake bit
  a_proc_host_hs: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_flag && !h_wr_flag |=> s_q.flag_q[FL_HOST_HS] == $past(s_q.flag_q[FL_HOST_HS]))
    else $error("processor changed host handshake bit");
  // Host flag writes leave the processor handshake bit
  a_host_proc_hs: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_flag && !p_wr_flag |=> s_q.flag_q[FL_PROC_HS] == $past(s_q.flag_q[FL_PROC_HS]))
    else $error("host changed processor handshake bit");
  // Host data write raises flag 7
  a_data_in_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_data |=> s_q.flag_q[FL_DATA_IN])
    else $error("host data write did not set flag");
  // Processor data read drops flag 7
  a_data_in_clr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_rd_data && !h_wr_data |=> !s_q.flag_q[FL_DATA_IN])
    else $error("processor data read did not clear flag");
  // Processor command write raises flag 2
  a_cmd_out_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_cmd |=> s_q.flag_q[FL_CMD_OUT])
    else $error("processor command write did not set flag");
  // Host command read drops flag 2
  a_cmd_out_clr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_rd_cmd && !p_wr_cmd |=> !s_q.flag_q[FL_CMD_OUT])
    else $error("host command read did not clear flag");
  // Host data read drops flag 6
  a_data_out_clr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_rd_data && !p_wr_data |=> !s_q.flag_q[FL_DATA_OUT])
    else $error("host data read did not clear flag");
  // Flag 7 moves only on data slot events
  a_data_flag_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(p_rd_data || h_wr_data) |=> s_q.flag_q[FL_DATA_IN] == $past(s_q.flag_q[FL_DATA_IN]))
    else $error("data flag changed without slot event");
  // Flag 2 moves only on command slot events
  a_cmd_flag_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !(h_rd_cmd || p_wr_cmd) |=> s_q.flag_q[FL_CMD_OUT] == $past(s_q.flag_q[FL_CMD_OUT]))
    else $error("outbound command flag changed without slot event");
  // Host interrupt needs a flag and its enable
  a_host_irq_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
    host_irq |-> $past(s_q.enable_q[EN_PORT]) &&
      $past(s_q.flag_q & s_q.enable_q & 8'h54) != 8'h00)
    else $error("host interrupt without flag and enable");
  // Enabled command flag interrupts the processor
  a_cmd_irq_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.enable_q[EN_PORT] && s_q.flag_q[FL_CMD_IN] && s_q.enable_q[EN_CMD_IN] |=> proc_irq)
    else $error("enabled command flag did not interrupt processor");
  // Enabled processor handshake interrupts the host
  a_proc_hs_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.enable_q[EN_PORT] && s_q.flag_q[FL_PROC_HS] && s_q.enable_q[EN_PROC_HS] |=> host_irq)
    else $error("enabled processor handshake did not interrupt host");
  // Host write fills the command slot
  a_cmd_slot_host: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_cmd && !p_wr_cmd |=> s_q.cmd_slot_q == $past(s_q.hdata_q))
    else $error("host command write lost");
  // Host write fills the data slot
  a_data_slot_host: assert property (@(posedge clk_sys) disable iff (sys_rst)
    h_wr_data && !p_wr_data |=> s_q.data_slot_q == $past(s_q.hdata_q))
    else $error("host data write lost");
  // Processor write fills the command slot
  a_slot_proc_wr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    p_wr_cmd |=> s_q.cmd_slot_q == $past(proc_wdata))
    else $error("processor command write lost");
  // Main scenarios
  c_host_cmd: cover property (@(posedge clk_sys) h_wr_cmd ##[1:20] p_rd_cmd);
  c_proc_data: cover property (@(posedge clk_sys) p_wr_data ##[1:40] h_rd_data);
  c_proc_irq: cover property (@(posedge clk_sys) $rose(proc_irq));
  c_host_irq: cover property (@(posedge clk_sys) $rose(host_irq));
  c_host_hs: cover property (@(posedge clk_sys) h_wr_flag ##[1:20] proc_irq);

endmodule : parallel_mailbox_port

// ---- verif/host_bus_model.sv ----
// Host processor model for the parallel mailbox port.
// Assumes the bench calls access() from its own process, at falling edges.
`timescale 1ns/1ps
module host_bus_model
  import mailbox_pkg::*;
(
  input wire logic clk_sys,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [2:0] slot_select,
  output logic [7:0] host_data_i,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe_n
);
  // Strobes idle high before reset is released
  initial begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    slot_select = 3'h0;
    host_data_i = 8'hA5;
  end
  // One host strobe: low 6 cycles, high 6 cycles
  task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d,
                        output logic [7:0] q, output logic oe_n);
    @(negedge clk_sys);
    slot_select = sel;
    host_data_i = d;
    if (wr) write_strobe_n = 1'b0;
    else read_strobe_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    q = host_data_o;
    oe_n = host_data_oe_n;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    // Released bus shows the inverse, not the last value
    host_data_i = ~d;
    repeat (6) @(negedge clk_sys);
  endtask : access
endmodule : host_bus_model

// ---- verif/testbench.sv ----
// Self-checking bench for the parallel mailbox port with a reference model.
// Assumes the host model and the design share one 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  import mailbox_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, proc_wr = 1'b0, proc_rd = 1'b0;
  logic [15:0] proc_addr = 16'h0000;
  logic [7:0] proc_wdata = 8'h00, proc_rdata, host_data_i, host_data_o;
  logic read_strobe_n, write_strobe_n, host_data_oe_n, proc_irq, host_irq;
  logic [2:0] slot_select;
  logic [7:0] en = 8'h00, fl = 8'h00, cmd = 8'h00, dat = 8'h00; // Model state
  logic [31:0] seed = 32'h05aba483;
  int err_count = 0, n_tests = 0;
  logic [15:0] paddr [5] = '{FLAG_ADDR, ENABLE_ADDR, CMD_SLOT_ADDR, DATA_SLOT_ADDR, 16'hDF7A};
  logic [2:0] hsel [5] = '{SEL_FLAG, SEL_ENABLE, SEL_CMD, SEL_DATA, 3'h2};
  parallel_mailbox_port i_parallel_mailbox_port (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .proc_addr(proc_addr), .proc_wr(proc_wr), .proc_rd(proc_rd), .proc_wdata(proc_wdata),
    .proc_rdata(proc_rdata), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .slot_select(slot_select), .host_data_i(host_data_i), .host_data_o(host_data_o),
    .host_data_oe_n(host_data_oe_n), .proc_irq(proc_irq), .host_irq(host_irq));
  host_bus_model i_host_bus_model (.clk_sys(clk_sys), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .slot_select(slot_select), .host_data_i(host_data_i),
    .host_data_o(host_data_o), .host_data_oe_n(host_data_oe_n));
  // Clock, 10 ns period
  always #5 clk_sys = ~clk_sys;
  // Pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Interrupt levels one cycle after the flag
  task automatic chk_irq;
    repeat (2) @(negedge clk_sys);
    chk({6'h0, proc_irq, host_irq}, {6'h0, en[0] & (fl[3] & en[3] | fl[7] & en[7] |
      fl[5] & en[5]), en[0] & (fl[2] & en[2] | fl[6] & en[6] | fl[4] & en[4])});
  endtask : chk_irq
  // Processor access, one-cycle pulse
  task automatic proc_op(input logic wr, input int k, input logic [7:0] d);
    logic [7:0] e;
    e = (k == 0) ? fl : (k == 1) ? en : (k == 2) ? cmd : (k == 3) ? dat : 8'h00;
    @(negedge clk_sys);
    proc_addr = paddr[k];
    proc_wdata = d;
    proc_wr = wr;
    proc_rd = !wr;
    @(negedge clk_sys);
    proc_wr = 1'b0;
    proc_rd = 1'b0;
    if (!wr) begin
      chk(proc_rdata, e);
      if (k == 2) fl[3] = 1'b0;
      if (k == 3) fl[7] = 1'b0;
    end else begin
      if (k == 0) fl[4] = d[4];
      if (k == 1) en = (en & HOST_EN_MASK) | (d & PROC_EN_MASK);
      if (k == 2) {cmd, fl[2]} = {d, 1'b1};
      if (k == 3) {dat, fl[6]} = {d, 1'b1};
    end
    chk_irq();
  endtask : proc_op
  // Host access, ignored unless port and strobes are on
  task automatic host_op(input logic wr, input int k, input logic [7:0] d);
    logic [7:0] q, e;
    logic oe_n, on;
    on = en[0] & en[1];
    e = (k == 0) ? fl : (k == 1) ? en : (k == 2) ? cmd : (k == 3) ? dat : 8'h00;
    i_host_bus_model.access(wr, hsel[k], d, q, oe_n);
    if (!wr) chk({7'h0, oe_n}, {7'h0, !on});
    if (!wr && on) chk(q, e);
    if (on && wr) begin
      if (k == 0) fl[5] = d[5];
      if (k == 1) en = (en & PROC_EN_MASK) | (d & HOST_EN_MASK);
      if (k == 2) {cmd, fl[3]} = {d, 1'b1};
      if (k == 3) {dat, fl[7]} = {d, 1'b1};
    end
    if (on && !wr && k == 2) fl[2] = 1'b0;
    if (on && !wr && k == 3) fl[6] = 1'b0;
    chk_irq();
  endtask : host_op
  // Directed start, then random traffic from both sides
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    proc_op(0, 0, 8'h00);
    proc_op(0, 1, 8'h00);
    host_op(1, 1, 8'hFF);
    proc_op(1, 1, 8'hFF);
    host_op(1, 1, 8'hFF);
    proc_op(0, 1, 8'h00);
    host_op(1, 1, 8'h00);
    proc_op(0, 1, 8'h00);
    for (int i = 0; i < 300; i++) begin
      seed = lfsr_next(seed);
      if (seed[4]) host_op(seed[3], int'(seed[2:0]) % 5, seed[15:8]);
      else proc_op(seed[3], int'(seed[2:0]) % 5,
        seed[15:8] | {6'h0, {2{seed[17:16] != 2'h0}}});
    end
    // Mid-run reset, then both registers must read back cleared
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    {en, fl} = 16'h0000;
    proc_op(0, 0, 8'h00);
    proc_op(0, 1, 8'h00);
    complete_run();
  end
  // Watchdog: the run needs some 3,000 cycles, this allows 20,000
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule : testbench
